// ===== design/ckg_clock_gen.sv
`timescale 1ns/1ns
// How it works
// - Strap code picks factor: 111x4,110x3,101x2,100x5,011x1,010x1.5,001/2,000x2.5
// - Code 001 divides the oscillator input by two
// - Prescaler phases each last one input period
// - Code 011 drives CPU clock straight from the input
// - Direct phases follow input duty; two halves make one period
// - Watchdog guards only direct and prescaler modes
// - Watchdog on after reset; config bit 4 set disables it
// - Free PLL ticks bump watchdog counter; input edges clear it
// - Sixteen ticks without edge: switch to PLL clock, flag interrupt
// - After failover stay on PLL until hardware reset
// - Watchdog disabled with no failover yet: clock from input, PLL off
// - Other codes enable PLL, clock is input times factor
// - PLL retunes every whole-factor transitions (x1.5: every one), one step each after loading the first period
// - Straps are sampled around reset to pick the mode
// - Half period is time between two CPU clock edges
module ckg_clock_gen
	import ckg_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire ckg_pkg::ckg_apb_req_t apb_req,
	output ckg_pkg::ckg_apb_rsp_t apb_rsp,
	input wire logic [2:0] clock_mode_strap_pins,
	input wire logic osc_input_pin,
	output logic cpu_clk,
	output logic pll_enable,
	output logic irq
);
	import ckg_pkg::*;

	// ----------------------------------------
	// Strap capture and free running PLL tick
	// ----------------------------------------
	ckg_mode_t mode_ff, nxt_mode;
	logic strap_taken_ff, nxt_strap_taken;
	logic pll_tick;
	logic wd_disable_ff, nxt_wd_disable;
	logic fail_ff, nxt_fail;
	logic wd_on;
	logic pll_mode;

	assign pll_mode = (mode_ff != MODE_DIV2) && (mode_ff != MODE_DIRECT);
	assign wd_on = strap_taken_ff && !pll_mode && !wd_disable_ff;

	ckg_tick #(.DIV(PLL_FREE_DIV)) u_pll_free (
		.pclk(pclk),
		.presetn(presetn),
		.run(wd_on || fail_ff),
		.tick(pll_tick)
	);

	always_comb begin
		nxt_mode = mode_ff;
		nxt_strap_taken = 1'b1;
		if (!strap_taken_ff) begin
			nxt_mode = ckg_mode_t'(clock_mode_strap_pins);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_ff <= MODE_X4;
			strap_taken_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			strap_taken_ff <= nxt_strap_taken;
		end
	end

	// ----------------------------------------
	// Oscillator edges and watchdog
	// ----------------------------------------
	logic osc_q_ff, nxt_osc_q;
	logic [3:0] wd_cnt_ff, nxt_wd_cnt;
	logic osc_edge;
	logic osc_rise;

	assign osc_edge = osc_input_pin != osc_q_ff;
	assign osc_rise = osc_input_pin && !osc_q_ff;

	always_comb begin
		nxt_osc_q = osc_input_pin;
		nxt_wd_cnt = wd_cnt_ff;
		nxt_fail = fail_ff;
		if (!wd_on || osc_edge) begin
			nxt_wd_cnt = 4'h0;
		end else if (pll_tick && !fail_ff) begin
			nxt_wd_cnt = wd_cnt_ff + 4'h1;
			if (wd_cnt_ff == WD_LAST_COUNT) begin
				nxt_fail = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_q_ff <= 1'b0;
			wd_cnt_ff <= 4'h0;
			fail_ff <= 1'b0;
		end else begin
			osc_q_ff <= nxt_osc_q;
			wd_cnt_ff <= nxt_wd_cnt;
			fail_ff <= nxt_fail;
		end
	end

	// ----------------------------------------
	// PLL multiplier
	// ----------------------------------------
	// Input must be slow against pclk: factor x2 below measured period
	logic [MEAS_W-1:0] meas_ff, nxt_meas;
	logic [MEAS_W-1:0] latest_ff, nxt_latest;
	logic [MEAS_W-1:0] period_ff, nxt_period;
	logic [MEAS_W-1:0] acc_ff, nxt_acc;
	logic [3:0] trans_ff, nxt_trans;
	logic [3:0] fx2;
	logic [3:0] resync_n;
	logic [MEAS_W:0] acc_sum;
	logic pll_toggle;

	assign fx2 = ckg_factor_x2(mode_ff);
	assign resync_n = (fx2 > 4'h3) ? (fx2 >> 1) : 4'h1;
	assign acc_sum = {1'b0, acc_ff} + {{(MEAS_W - 3){1'b0}}, fx2};
	assign pll_toggle = pll_mode && strap_taken_ff && (period_ff != '0) && (acc_sum >= {1'b0, period_ff});

	always_comb begin
		nxt_meas = meas_ff;
		nxt_latest = latest_ff;
		nxt_period = period_ff;
		nxt_acc = acc_ff;
		nxt_trans = trans_ff;
		if (pll_mode && strap_taken_ff) begin
			nxt_meas = (meas_ff == '1) ? meas_ff : meas_ff + 1'b1;
			if (osc_rise) begin
				nxt_meas = 16'h0001;
				nxt_latest = meas_ff;
			end
			if (osc_edge) begin
				nxt_trans = trans_ff + 4'h1;
				if (trans_ff + 4'h1 >= resync_n) begin
					nxt_trans = 4'h0;
					if (period_ff == '0) begin
						nxt_period = latest_ff;
					end else if (latest_ff > period_ff) begin
						nxt_period = period_ff + 1'b1;
					end else if (latest_ff < period_ff) begin
						nxt_period = period_ff - 1'b1;
					end
				end
			end
			if (period_ff != '0) begin
				nxt_acc = pll_toggle ? MEAS_W'(acc_sum - {1'b0, period_ff}) : acc_sum[MEAS_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas_ff <= '0;
			latest_ff <= '0;
			period_ff <= '0;
			acc_ff <= '0;
			trans_ff <= 4'h0;
		end else begin
			meas_ff <= nxt_meas;
			latest_ff <= nxt_latest;
			period_ff <= nxt_period;
			acc_ff <= nxt_acc;
			trans_ff <= nxt_trans;
		end
	end

	// ----------------------------------------
	// CPU clock source
	// ----------------------------------------
	logic cpu_clk_ff, nxt_cpu_clk;
	logic pll_en_ff, nxt_pll_en;

	always_comb begin
		nxt_cpu_clk = cpu_clk_ff;
		nxt_pll_en = strap_taken_ff && (pll_mode || wd_on || fail_ff);
		if (!strap_taken_ff) begin
			nxt_cpu_clk = 1'b0;
		end else if (fail_ff) begin
			if (pll_tick) begin
				nxt_cpu_clk = !cpu_clk_ff;
			end
		end else if (pll_mode) begin
			if (pll_toggle) begin
				nxt_cpu_clk = !cpu_clk_ff;
			end
		end else if (mode_ff == MODE_DIV2) begin
			if (osc_rise) begin
				nxt_cpu_clk = !cpu_clk_ff;
			end
		end else begin
			nxt_cpu_clk = osc_input_pin;
		end
	end

	// each edge ends a half period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_clk_ff <= 1'b0;
			pll_en_ff <= 1'b0;
		end else begin
			cpu_clk_ff <= nxt_cpu_clk;
			pll_en_ff <= nxt_pll_en;
		end
	end

	assign cpu_clk = cpu_clk_ff;
	assign pll_enable = pll_en_ff;

	// ----------------------------------------
	// APB registers and interrupt
	// ----------------------------------------
	logic irq_stat_ff, nxt_irq_stat;
	logic irq_mask_ff, nxt_irq_mask;
	logic irq_ff, nxt_irq;
	ckg_apb_rsp_t rsp_ff, nxt_rsp;
	logic wr_go;
	logic rd_go;
	logic hit;

	// One wait state: pready rises in the second access cycle
	assign wr_go = apb_req.psel && apb_req.penable && rsp_ff.pready && apb_req.pwrite;
	assign rd_go = apb_req.psel && apb_req.penable && !rsp_ff.pready;
	assign hit = apb_req.paddr == ADDR_SYSCFG || apb_req.paddr == ADDR_IRQ_STATUS
		|| apb_req.paddr == ADDR_IRQ_MASK || apb_req.paddr == ADDR_CLK_STATE;

	always_comb begin
		nxt_wd_disable = wd_disable_ff;
		nxt_irq_mask = irq_mask_ff;
		nxt_irq_stat = irq_stat_ff;
		nxt_rsp = '0;
		if (rd_go) begin
			nxt_rsp.pready = 1'b1;
			nxt_rsp.pslverr = !hit;
			if (!apb_req.pwrite) begin
				case (apb_req.paddr)
					ADDR_SYSCFG: nxt_rsp.prdata[WD_DISABLE_BIT] = wd_disable_ff;
					ADDR_IRQ_STATUS: nxt_rsp.prdata[IRQ_OSC_FAIL_BIT] = irq_stat_ff;
					ADDR_IRQ_MASK: nxt_rsp.prdata[IRQ_OSC_FAIL_BIT] = irq_mask_ff;
					ADDR_CLK_STATE: nxt_rsp.prdata = {26'h0, pll_en_ff, fail_ff, wd_on, 3'(mode_ff)};
					default: nxt_rsp.prdata = 32'h0000_0000;
				endcase
			end
		end
		if (wr_go) begin
			case (apb_req.paddr)
				ADDR_SYSCFG: nxt_wd_disable = apb_req.pwdata[WD_DISABLE_BIT];
				ADDR_IRQ_STATUS: begin
					if (apb_req.pwdata[IRQ_OSC_FAIL_BIT]) begin
						nxt_irq_stat = 1'b0;
					end
				end
				ADDR_IRQ_MASK: nxt_irq_mask = apb_req.pwdata[IRQ_OSC_FAIL_BIT];
				default: nxt_irq_mask = irq_mask_ff;
			endcase
		end
		if (nxt_fail && !fail_ff) begin
			nxt_irq_stat = 1'b1;
		end
		nxt_irq = nxt_irq_stat && nxt_irq_mask;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_disable_ff <= SYSCFG_RESET[WD_DISABLE_BIT];
			irq_mask_ff <= IRQ_MASK_RESET[IRQ_OSC_FAIL_BIT];
			irq_stat_ff <= 1'b0;
			irq_ff <= 1'b0;
			rsp_ff <= '0;
		end else begin
			wd_disable_ff <= nxt_wd_disable;
			irq_mask_ff <= nxt_irq_mask;
			irq_stat_ff <= nxt_irq_stat;
			irq_ff <= nxt_irq;
			rsp_ff <= nxt_rsp;
		end
	end

	assign apb_rsp = rsp_ff;
	assign irq = irq_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_strap_hold;
		@(posedge pclk) disable iff (!presetn) strap_taken_ff |=> $stable(mode_ff);
	endproperty
	a_strap_hold: assert property (p_strap_hold) else $error("mode changed after capture");

	property p_strap_take;
		@(posedge pclk) disable iff (!presetn) !strap_taken_ff |=> mode_ff == ckg_mode_t'($past(clock_mode_strap_pins));
	endproperty
	a_strap_take: assert property (p_strap_take) else $error("strap not captured");

	property p_direct;
		@(posedge pclk) disable iff (!presetn)
		(mode_ff == MODE_DIRECT && strap_taken_ff && !fail_ff && !nxt_fail) |=> cpu_clk == $past(osc_input_pin);
	endproperty
	a_direct: assert property (p_direct) else $error("direct clock does not follow input");

	property p_div2;
		@(posedge pclk) disable iff (!presetn)
		(mode_ff == MODE_DIV2 && strap_taken_ff && !fail_ff && !osc_rise) |=> $stable(cpu_clk);
	endproperty
	a_div2: assert property (p_div2) else $error("prescaler toggled without input rise");

	property p_fail_set;
		@(posedge pclk) disable iff (!presetn)
		(wd_on && !fail_ff && pll_tick && !osc_edge && wd_cnt_ff == WD_LAST_COUNT) |=> fail_ff && irq_stat_ff;
	endproperty
	a_fail_set: assert property (p_fail_set) else $error("watchdog overflow missed");

	property p_fail_sticky;
		@(posedge pclk) disable iff (!presetn) fail_ff |=> fail_ff ##1 fail_ff;
	endproperty
	a_fail_sticky: assert property (p_fail_sticky) else $error("failover left PLL");

	property p_wd_clear;
		@(posedge pclk) disable iff (!presetn) osc_edge |=> wd_cnt_ff == 4'h0;
	endproperty
	a_wd_clear: assert property (p_wd_clear) else $error("input edge did not clear counter");

	property p_pll_off;
		@(posedge pclk) disable iff (!presetn)
		(!pll_mode && wd_disable_ff && !fail_ff && strap_taken_ff) |=> !pll_enable;
	endproperty
	a_pll_off: assert property (p_pll_off) else $error("PLL on while watchdog disabled");

	property p_fail_phase;
		@(posedge pclk) disable iff (!presetn) (fail_ff && $changed(cpu_clk)) |=> $stable(cpu_clk);
	endproperty
	a_fail_phase: assert property (p_fail_phase) else $error("short phase after failover");

	property p_irq_hold;
		@(posedge pclk) disable iff (!presetn) (irq_stat_ff && !wr_go) |=> irq_stat_ff;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("failure flag dropped");

	property p_pll_on;
		@(posedge pclk) disable iff (!presetn) (pll_mode && strap_taken_ff) |=> pll_enable;
	endproperty
	a_pll_on: assert property (p_pll_on) else $error("PLL off in multiplier mode");

	c_failover: cover property (@(posedge pclk) disable iff (!presetn) !fail_ff ##1 fail_ff);
	c_pll_toggle: cover property (@(posedge pclk) disable iff (!presetn) pll_toggle ##[1:40] pll_toggle);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
	c_wd_off: cover property (@(posedge pclk) disable iff (!presetn) wd_disable_ff && !pll_mode);
endmodule : ckg_clock_gen

// ===== design/ckg_pkg.sv
package ckg_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_SYSCFG = 8'h00;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
	localparam logic [7:0] ADDR_CLK_STATE = 8'h0c;
	localparam int WD_DISABLE_BIT = 4;
	localparam int IRQ_OSC_FAIL_BIT = 0;
	localparam logic [31:0] SYSCFG_RESET = 32'h0000_0000;
	localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int PCLK_PERIOD_NS = 100;
	localparam int PLL_FREE_PERIOD_NS = 300;
	localparam int PLL_FREE_DIV = (PLL_FREE_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
	localparam logic [3:0] WD_LAST_COUNT = 4'hf;
	localparam int MEAS_W = 16;

	// ----------------------------------------
	// Strap codes and factors in halves
	// ----------------------------------------
	typedef enum logic [2:0] {
		MODE_X2P5 = 3'b000,
		MODE_DIV2 = 3'b001,
		MODE_X1P5 = 3'b010,
		MODE_DIRECT = 3'b011,
		MODE_X5 = 3'b100,
		MODE_X2 = 3'b101,
		MODE_X3 = 3'b110,
		MODE_X4 = 3'b111
	} ckg_mode_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ckg_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ckg_apb_rsp_t;

	function automatic logic [3:0] ckg_factor_x2(input ckg_mode_t m);
		case (m)
			MODE_X4: ckg_factor_x2 = 4'h8;
			MODE_X3: ckg_factor_x2 = 4'h6;
			MODE_X2: ckg_factor_x2 = 4'h4;
			MODE_X5: ckg_factor_x2 = 4'ha;
			MODE_DIRECT: ckg_factor_x2 = 4'h2;
			MODE_X1P5: ckg_factor_x2 = 4'h3;
			MODE_DIV2: ckg_factor_x2 = 4'h1;
			MODE_X2P5: ckg_factor_x2 = 4'h5;
			default: ckg_factor_x2 = 4'h8;
		endcase
	endfunction : ckg_factor_x2

endpackage : ckg_pkg

// ===== design/ckg_tick.sv
`timescale 1ns/1ns
module ckg_tick #(
	parameter int DIV = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	output logic tick
);
	localparam int CW = $clog2(DIV + 1);
	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic tick_ff;
	logic nxt_tick;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_tick = 1'b0;
		if (!run) begin
			nxt_cnt = '0;
		end else if (cnt_ff == CW'(DIV - 1)) begin
			nxt_cnt = '0;
			nxt_tick = 1'b1;
		end else begin
			nxt_cnt = cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule : ckg_tick

// ===== tb/ckg_osc_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Oscillator source, pclk aligned
// ----------------------------------------
module ckg_osc_model (
	input wire logic pclk,
	input wire logic run,
	input wire logic [31:0] hi_len,
	input wire logic [31:0] lo_len,
	output logic osc
);
	int cnt = 0;
	initial osc = 1'b0;
	// A stopped crystal holds its last level
	always @(posedge pclk) begin
		if (run) begin
			cnt <= cnt + 1;
			if (cnt + 1 >= (osc ? hi_len : lo_len)) begin
				osc <= ~osc;
				cnt <= 0;
			end
		end
	end
endmodule : ckg_osc_model

// ===== tb/ckg_clock_gen_tb.sv
`timescale 1ns/1ns
module ckg_clock_gen_tb;
	import ckg_pkg::*;
	logic pclk = 1'b0;
	logic presetn;
	ckg_apb_req_t req;
	ckg_apb_rsp_t rsp;
	logic [2:0] straps;
	logic osc, run, cpu_clk, pll_enable, irq;
	int hi_len, lo_len, errors, total_checks;
	logic [31:0] rd;
	logic err;

	always #50 pclk = ~pclk;

	ckg_clock_gen dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.clock_mode_strap_pins(straps), .osc_input_pin(osc), .cpu_clk(cpu_clk),
		.pll_enable(pll_enable), .irq(irq));
	ckg_osc_model osc_src (.pclk(pclk), .run(run), .hi_len(hi_len), .lo_len(lo_len), .osc(osc));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task report_and_stop();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 20) begin
			errors++;
			report_and_stop();
		end
	endtask : apb

	task do_reset(input logic [2:0] code);
		@(posedge pclk);
		presetn <= 1'b0;
		straps <= code;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		// Later strap moves must be ignored
		straps <= ~code;
	endtask : do_reset

	// Phase lengths of cpu_clk in pclk cycles
	task meas(output int hi, output int lo);
		int n;
		n = 0;
		hi = 0;
		lo = 0;
		@(negedge pclk);
		while (cpu_clk !== 1'b0 && n < 200) begin
			@(negedge pclk);
			n++;
		end
		while (cpu_clk !== 1'b1 && n < 200) begin
			@(negedge pclk);
			n++;
		end
		while (cpu_clk === 1'b1 && n < 200) begin
			@(negedge pclk);
			hi++;
			n++;
		end
		while (cpu_clk === 1'b0 && n < 200) begin
			@(negedge pclk);
			lo++;
			n++;
		end
		if (n >= 200) begin
			errors++;
			report_and_stop();
		end
	endtask : meas

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_straps();
		logic wd;
		for (int c = 0; c < 8; c++) begin
			do_reset(c[2:0]);
			wd = (c == 1 || c == 3);
			apb(1'b0, ADDR_CLK_STATE, 32'h0);
			chk(rd, {26'h0, 1'b1, 1'b0, wd, c[2:0]});
			chk(pll_enable, 1'b1);
		end
		apb(1'b0, ADDR_SYSCFG, 32'h0);
		chk(rd, SYSCFG_RESET);
		apb(1'b0, ADDR_IRQ_MASK, 32'h0);
		chk(rd, IRQ_MASK_RESET);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b1);
	endtask : t_straps

	task t_direct();
		int hi, lo;
		do_reset(MODE_DIRECT);
		meas(hi, lo);
		chk(hi, 3);
		chk(lo, 1);
		apb(1'b1, ADDR_SYSCFG, 32'h10);
		apb(1'b0, ADDR_SYSCFG, 32'h0);
		chk(rd, 32'h10);
		repeat (3) @(posedge pclk);
		chk(pll_enable, 1'b0);
		meas(hi, lo);
		chk(hi, 3);
		chk(lo, 1);
		@(posedge pclk);
		run <= 1'b0;
		repeat (60) @(posedge pclk);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd, 32'h0);
		run <= 1'b1;
	endtask : t_direct

	task t_fail();
		int hi, lo;
		do_reset(MODE_DIV2);
		meas(hi, lo);
		chk(hi, 4);
		chk(lo, 4);
		@(posedge pclk);
		run <= 1'b0;
		repeat (34) @(posedge pclk);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd, 32'h0);
		repeat (20) @(posedge pclk);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd, 32'h1);
		chk(irq, 1'b0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b1);
		run <= 1'b1;
		apb(1'b0, ADDR_CLK_STATE, 32'h0);
		chk(rd[4], 1'b1);
		meas(hi, lo);
		chk(hi, 3);
		chk(lo, 3);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 1'b0);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd, 32'h0);
	endtask : t_fail

	// Toggles of cpu_clk over 160 cycles once the loop has settled
	task pll_count(input logic [2:0] code, output int cnt);
		logic last;
		do_reset(code);
		repeat (300) @(posedge pclk);
		cnt = 0;
		@(negedge pclk);
		last = cpu_clk;
		repeat (160) begin
			@(negedge pclk);
			cnt += (cpu_clk !== last);
			last = cpu_clk;
		end
	endtask : pll_count

	task t_pll();
		int cnt;
		hi_len <= 8;
		lo_len <= 8;
		// Three toggles per 16-cycle input period, one step of slack
		pll_count(MODE_X1P5, cnt);
		chk(cnt >= 29 && cnt <= 31, 1'b1);
		// Eight toggles per 16-cycle input period, two steps of slack
		pll_count(MODE_X4, cnt);
		chk(cnt >= 78 && cnt <= 82, 1'b1);
		@(posedge pclk);
		run <= 1'b0;
		repeat (80) @(posedge pclk);
		apb(1'b0, ADDR_IRQ_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ADDR_CLK_STATE, 32'h0);
		chk(rd[3], 1'b0);
	endtask : t_pll

	initial begin
		req = '0;
		presetn = 1'b0;
		straps = 3'b111;
		run = 1'b1;
		hi_len = 3;
		lo_len = 1;
		errors = 0;
		total_checks = 0;
		t_straps();
		t_direct();
		t_fail();
		t_pll();
		report_and_stop();
	end
endmodule : ckg_clock_gen_tb
